/* hw/uhif_flag_bit.sv */
/*
  One sticky flag bit: set by a hardware event, cleared by a software
  write of zero or by the controller soft reset unless kept.
  Assumes all inputs come from logic on pclk.
*/
`default_nettype none

module uhif_flag_bit #(
  parameter bit KEEP_ON_SRST = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_ev,
  input  wire logic wr_clear,
  input  wire logic soft_rst,
  output logic      flag
);

  typedef struct packed {
    logic flag;
  } uhif_flag_state_s;

  uhif_flag_state_s st_reg;
  uhif_flag_state_s st_next;

  // ==========================================================
  // next state: an event in the clearing cycle wins
  always_comb begin
    st_next = st_reg;
    if (set_ev) begin
      st_next.flag = 1'b1;
    end else if (wr_clear || (soft_rst && !KEEP_ON_SRST)) begin
      st_next.flag = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign flag = st_reg.flag;

endmodule

`default_nettype wire

/* hw/uhif_top.sv */
/*
  Host interrupt flag block: seven sticky host event flags behind APB,
  interrupt enables for all but the cancel flag, the token cancel enable, the soft reset
  level and a level interrupt output.
  Assumes events are one-cycle pulses from the controller on pclk and
  that the bus fabric raises prmw during the read of a read-modify-write.
*/
`default_nettype none

module uhif_top
  import uhif_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [UHIF_AW-1:0] paddr,
  input  wire logic [UHIF_DW-1:0] pwdata,
  input  wire logic [UHIF_SW-1:0] pstrb,
  input  wire logic               prmw,
  output logic      [UHIF_DW-1:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               ev_wakeup_end,
  input  wire logic               ev_bus_reset_end,
  input  wire logic               ev_token_done,
  input  wire logic               ev_attach,
  input  wire logic               ev_detach,
  input  wire logic               ev_frame_start,
  input  wire logic               token_req,
  input  wire logic               eof_window,
  output logic                    token_go,
  output logic                    core_soft_rst,
  output logic                    host_irq
);

  // ==========================================================
  // state
  typedef struct packed {
    logic [UHIF_DW-1:0] prdata;
    logic               pready;
    logic               pslverr;
    logic [UHIF_FW-1:0] int_en;
    logic               cancel_en;
    logic               soft_rst;
    logic               irq;
    logic               token_go;
  } uhif_top_state_s;

  uhif_top_state_s st_reg;
  uhif_top_state_s st_next;

  logic [UHIF_FW-1:0] flags;
  logic [UHIF_FW-1:0] ev_vec;
  logic [UHIF_FW-1:0] clr_vec;
  logic               setup_ph;
  logic               wr_done;
  logic               cancel_now;
  logic               flags_wr;

  // ==========================================================
  // bus phases
  // requests are answered with zero wait states; pready is a flop set in
  // the setup cycle so the access phase completes at its first edge
  assign setup_ph = psel && !penable;
  assign wr_done  = psel && penable && st_reg.pready && pwrite;
  // a refused flag write (wrong byte lanes) leaves the flags alone
  assign flags_wr = wr_done && !st_reg.pslverr && (paddr == UHIF_ADDR_FLAGS);

  // ==========================================================
  // token cancel and events
  // a cancelled token is never sent, so it can never report completion
  assign cancel_now = token_req && st_reg.cancel_en && eof_window;

  always_comb begin
    ev_vec                  = '0;
    ev_vec[UHIF_BIT_CANCEL] = cancel_now;
    ev_vec[UHIF_BIT_WAKE]   = ev_wakeup_end;
    ev_vec[UHIF_BIT_BRST]   = ev_bus_reset_end;
    ev_vec[UHIF_BIT_DONE]   = ev_token_done && !cancel_now;
    ev_vec[UHIF_BIT_ATT]    = ev_attach;
    ev_vec[UHIF_BIT_DET]    = ev_detach;
    ev_vec[UHIF_BIT_SOF]    = ev_frame_start;
  end

  // zero in a written bit clears it, one leaves it
  assign clr_vec = flags_wr ? ~pwdata[UHIF_FW-1:0] : '0;

  // ==========================================================
  // flag bits
  genvar gi;
  generate
    for (gi = 0; gi < UHIF_FW; gi++) begin : g_flag
      if (gi == UHIF_BIT_RSVD) begin : g_rsvd
        assign flags[gi] = 1'b0;
      end else begin : g_impl
        uhif_flag_bit #(
          .KEEP_ON_SRST (UHIF_SRST_KEEP[gi])
        ) u_flag (
          .pclk     (pclk),
          .presetn  (presetn),
          .set_ev   (ev_vec[gi]),
          .wr_clear (clr_vec[gi]),
          .soft_rst (st_reg.soft_rst),
          .flag     (flags[gi])
        );
      end
    end
  endgenerate

  // ==========================================================
  // next state
  always_comb begin
    st_next          = st_reg;
    st_next.pready   = setup_ph;
    st_next.token_go = token_req && !cancel_now;
    // cancel flag has no enable and is masked out of the interrupt
    st_next.irq      = |(flags & st_reg.int_en & UHIF_INT_MASK);

    if (setup_ph) begin
      st_next.prdata  = '0;
      st_next.pslverr = 1'b0;
      if (paddr == UHIF_ADDR_FLAGS) begin
        if (pwrite && (pstrb != UHIF_STRB_BYTE0)) begin
          st_next.pslverr = 1'b1;
        end
        if (!pwrite && prmw) begin
          // read half of read-modify-write sees ones in the UHIF_RMW_ONES_MASK flags (all but bit3)
          // so the write back cannot clear one of those that was not meant to be touched
          st_next.prdata[UHIF_FW-1:0] = flags | UHIF_RMW_ONES_MASK;
        end else begin
          st_next.prdata[UHIF_FW-1:0] = flags;
        end
      end else if (paddr == UHIF_ADDR_CTL0) begin
        st_next.prdata[UHIF_FW-1:0] = st_reg.int_en;
      end else if (paddr == UHIF_ADDR_CTL1) begin
        st_next.prdata[UHIF_BIT_CANCEL_EN] = st_reg.cancel_en;
      end else if (paddr == UHIF_ADDR_CORE) begin
        st_next.prdata[UHIF_BIT_SOFT_RST] = st_reg.soft_rst;
      end else begin
        st_next.pslverr = 1'b1;
      end
    end else if (!psel) begin
      st_next.pslverr = 1'b0;
    end

    if (wr_done && !st_reg.pslverr) begin
      if (paddr == UHIF_ADDR_CTL0) begin
        st_next.int_en = pwdata[UHIF_FW-1:0] & UHIF_INT_MASK;
      end else if (paddr == UHIF_ADDR_CTL1) begin
        st_next.cancel_en = pwdata[UHIF_BIT_CANCEL_EN];
      end else if (paddr == UHIF_ADDR_CORE) begin
        st_next.soft_rst = pwdata[UHIF_BIT_SOFT_RST];
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg           <= '0;
      st_reg.int_en    <= UHIF_EN_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata        = st_reg.prdata;
  assign pready        = st_reg.pready;
  assign pslverr       = st_reg.pslverr;
  assign token_go      = st_reg.token_go;
  assign core_soft_rst = st_reg.soft_rst;
  assign host_irq      = st_reg.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup_flags_rd;
    psel && !penable && !pwrite && (paddr == UHIF_ADDR_FLAGS);
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  chk_irq_enabled_or: assert property (
    ##1 host_irq == $past(|(flags & st_reg.int_en & UHIF_INT_MASK)))
    else $error("interrupt does not follow enabled flags");

  chk_cancel_no_irq: assert property (
    (flags == (8'h80)) |=> !host_irq)
    else $error("cancel flag alone raised the interrupt");

  // any write (enable or flag clear) or a soft reset may legally drop the request, so they are left out
  chk_irq_holds: assert property (
    ((flags & st_reg.int_en) != 8'h00) && !wr_done && !st_reg.soft_rst |=> ##1 host_irq)
    else $error("interrupt dropped with enabled flag set");

  chk_write_zero_clr: assert property (
    flags_wr && (ev_vec == 8'h00)
      |=> (flags & ~$past(pwdata[UHIF_FW-1:0])) == 8'h00)
    else $error("write of zero did not clear flag");

  chk_write_one_keep: assert property (
    flags_wr && !st_reg.soft_rst
      |=> (flags & $past(flags))
          == ($past(flags) & ($past(pwdata[UHIF_FW-1:0]) | $past(ev_vec))))
    else $error("write of one changed a flag");

  chk_rmw_ones: assert property (
    s_setup_flags_rd ##0 prmw
      |=> s_access ##0 ((prdata[UHIF_FW-1:0] & UHIF_RMW_ONES_MASK) == UHIF_RMW_ONES_MASK))
    else $error("read-modify-write did not read ones");

  chk_cancel_sets: assert property (
    token_req && eof_window && st_reg.cancel_en |=> flags[UHIF_BIT_CANCEL] && !token_go)
    else $error("cancelled token not flagged or still sent");

  chk_done_not_cancel: assert property (
    cancel_now && !flags[UHIF_BIT_DONE] && !flags_wr && !st_reg.soft_rst
      |=> !flags[UHIF_BIT_DONE])
    else $error("cancelled token set completion flag");

  chk_event_sets: assert property (
    ev_vec != 8'h00 |=> (flags & $past(ev_vec)) == $past(ev_vec))
    else $error("event did not set its flag");

  chk_rsvd_zero: assert property (
    ##1 !flags[UHIF_BIT_RSVD] && (prdata[UHIF_DW-1:UHIF_FW] == 24'h000000))
    else $error("reserved bits read nonzero");

  chk_srst_keeps: assert property (
    st_reg.soft_rst && (ev_vec == 8'h00) && !flags_wr
      |=> ((flags & ~UHIF_SRST_KEEP) == 8'h00)
          && ((flags & UHIF_SRST_KEEP) == ($past(flags) & UHIF_SRST_KEEP)))
    else $error("soft reset handled flags wrongly");

  chk_bad_strb_refused: assert property (
    psel && !penable && pwrite && (paddr == UHIF_ADDR_FLAGS) && (pstrb != UHIF_STRB_BYTE0)
      ##1 s_access ##0 ((ev_vec == 8'h00) && !st_reg.soft_rst)
      |-> pslverr ##1 (flags == $past(flags)))
    else $error("wide flag write not refused");

endmodule

`default_nettype wire

/* inc/uhif_pkg.sv */
/*
  Constants for the host-side interrupt flag block of a USB host controller:
  register offsets, bit positions, masks and reset values.
  Assumes an APB slave with 32-bit data and byte addresses on paddr.
*/
// Behaviour
// - interrupt only from flags whose enable is set
// - writing zero clears a flag, one ignored
// - read-modify-write reads listed flags as one
// - cancelled token sets cancel flag bit7
// - cancel flag never raises the interrupt
// - wake-up end sets bit5, interrupts if enabled
// - bus reset end sets bit4, interrupts if enabled
// - token completion sets bit3, interrupts if enabled
// - cancelled token never sets completion flag
// - attach sets bit2 in any mode, interrupts if enabled
// - detach sets bit1 in any mode, interrupts if enabled
// - frame start sets bit0, interrupts if enabled
// - flags reset; soft reset spares attach and detach
// - token in end-of-frame window cancelled when enabled
`default_nettype none

package uhif_pkg;

  // ==========================================================
  // bus
  localparam int unsigned UHIF_AW = 8;
  localparam int unsigned UHIF_DW = 32;
  localparam int unsigned UHIF_SW = 4;

  localparam logic [7:0] UHIF_ADDR_FLAGS = 8'h00;
  localparam logic [7:0] UHIF_ADDR_CTL0  = 8'h04;
  localparam logic [7:0] UHIF_ADDR_CTL1  = 8'h08;
  localparam logic [7:0] UHIF_ADDR_CORE  = 8'h0C;

  localparam logic [3:0] UHIF_STRB_BYTE0 = 4'h1;

  // ==========================================================
  // flag register layout
  localparam int unsigned UHIF_FW         = 8;
  localparam int unsigned UHIF_BIT_CANCEL = 7;
  localparam int unsigned UHIF_BIT_RSVD   = 6;
  localparam int unsigned UHIF_BIT_WAKE   = 5;
  localparam int unsigned UHIF_BIT_BRST   = 4;
  localparam int unsigned UHIF_BIT_DONE   = 3;
  localparam int unsigned UHIF_BIT_ATT    = 2;
  localparam int unsigned UHIF_BIT_DET    = 1;
  localparam int unsigned UHIF_BIT_SOF    = 0;

  localparam logic [7:0] UHIF_FLAGS_RST     = 8'h00;
  localparam logic [7:0] UHIF_INT_MASK      = 8'h3F;
  localparam logic [7:0] UHIF_RMW_ONES_MASK = 8'hB7;
  localparam logic [7:0] UHIF_SRST_KEEP     = 8'h06;

  // ==========================================================
  // control registers
  localparam logic [7:0] UHIF_EN_RST          = 8'h00;
  localparam int unsigned UHIF_BIT_CANCEL_EN  = 0;
  localparam int unsigned UHIF_BIT_SOFT_RST   = 0;

endpackage

`default_nettype wire

/* test/usb_host_interrupt_flags_tb.sv */
/*
  Self-checking bench for the host interrupt flag block: APB tasks,
  event pulses, token requests and the verdict.
  Assumes uhif_pkg and uhif_top are compiled before this file.
*/
`default_nettype none

module usb_host_interrupt_flags_tb
  import uhif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // signals
  logic               pclk;
  logic               presetn;
  logic               psel;
  logic               penable;
  logic               pwrite;
  logic               prmw;
  logic [UHIF_AW-1:0] paddr;
  logic [UHIF_DW-1:0] pwdata;
  logic [UHIF_SW-1:0] pstrb;
  logic [UHIF_DW-1:0] prdata;
  logic               pready;
  logic               pslverr;
  logic [5:0]         ev;
  logic               token_req;
  logic               eof_window;
  logic               token_go;
  logic               core_soft_rst;
  logic               host_irq;
  logic [UHIF_DW-1:0] rd;
  logic               err;
  logic               go_seen;
  int                 n_errors;
  int                 tests_run;
  int                 i;
  int                 cyc = 0;

  uhif_top uhif_top_inst (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pstrb            (pstrb),
    .prmw             (prmw),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .ev_wakeup_end    (ev[5]),
    .ev_bus_reset_end (ev[4]),
    .ev_token_done    (ev[3]),
    .ev_attach        (ev[2]),
    .ev_detach        (ev[1]),
    .ev_frame_start   (ev[0]),
    .token_req        (token_req),
    .eof_window       (eof_window),
    .token_go         (token_go),
    .core_soft_rst    (core_soft_rst),
    .host_irq         (host_irq)
  );

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // ==========================================================
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic rmw);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    prmw    <= rmw;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    prmw    <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic rmw, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 4'h0, rmw);
    check(rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, UHIF_STRB_BYTE0, 1'b0);
  endtask

  // leaves two edges so a registered interrupt has landed
  task automatic pulse(input logic [5:0] e);
    @(posedge pclk);
    ev <= e;
    @(posedge pclk);
    ev <= 6'h00;
    repeat (2) @(posedge pclk);
  endtask

  task automatic token(input logic [5:0] e);
    @(posedge pclk);
    token_req <= 1'b1;
    ev        <= e;
    @(posedge pclk);
    token_req <= 1'b0;
    ev        <= 6'h00;
    @(posedge pclk);
    go_seen = token_go;
    repeat (2) @(posedge pclk);
  endtask

  task automatic wrap_up();
    $display("Checks run %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ==========================================================
  // timeout: the sequence needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ==========================================================
  // sequence
  initial begin
    {psel, penable, pwrite, prmw, token_req, eof_window} = 6'h00;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    ev = '0;
    n_errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 4; i++) rd_chk(8'(4 * i), 1'b0, 32'h0);
    for (i = 0; i < 6; i++) begin
      pulse(6'(1 << i));
      check({31'h0, host_irq}, 32'h0);
      rd_chk(UHIF_ADDR_FLAGS, 1'b0, 32'(1 << i));
      wr(UHIF_ADDR_FLAGS, 32'hBF);
      rd_chk(UHIF_ADDR_FLAGS, 1'b0, 32'(1 << i));
      wr(UHIF_ADDR_CTL0, 32'hC0 | 32'(1 << i));
      rd_chk(UHIF_ADDR_CTL0, 1'b0, 32'(1 << i));
      check({31'h0, host_irq}, 32'h1);
      wr(UHIF_ADDR_CTL0, 32'h0);
      repeat (2) @(posedge pclk);
      check({31'h0, host_irq}, 32'h0);
      wr(UHIF_ADDR_FLAGS, 32'hBF & ~32'(1 << i));
      rd_chk(UHIF_ADDR_FLAGS, 1'b0, 32'h0);
    end
    pulse(6'h0C);
    rd_chk(UHIF_ADDR_FLAGS, 1'b1, 32'hBF);
    rd_chk(UHIF_ADDR_FLAGS, 1'b0, 32'h0C);
    apb(1'b1, UHIF_ADDR_FLAGS, 32'h0, 4'hF, 1'b0);
    check({31'h0, err}, 32'h1);
    rd_chk(UHIF_ADDR_FLAGS, 1'b0, 32'h0C);
    rd_chk(8'h10, 1'b0, 32'h0);
    check({31'h0, err}, 32'h1);
    pulse(6'h3F);
    wr(UHIF_ADDR_CTL0, 32'h3F);
    wr(UHIF_ADDR_CORE, 32'h1);
    @(posedge pclk);
    check({31'h0, core_soft_rst}, 32'h1);
    wr(UHIF_ADDR_CORE, 32'h0);
    rd_chk(UHIF_ADDR_FLAGS, 1'b0, 32'h06);
    rd_chk(UHIF_ADDR_CTL0, 1'b0, 32'h3F);
    check({31'h0, host_irq}, 32'h1);
    wr(UHIF_ADDR_FLAGS, 32'h0);
    @(posedge pclk);
    eof_window <= 1'b1;
    token(6'h00);
    check({31'h0, go_seen}, 32'h1);
    wr(UHIF_ADDR_CTL1, 32'h1);
    token(6'h08);
    check({31'h0, go_seen}, 32'h0);
    check({31'h0, host_irq}, 32'h0);
    rd_chk(UHIF_ADDR_FLAGS, 1'b0, 32'h80);
    rd_chk(UHIF_ADDR_FLAGS, 1'b1, 32'hB7);
    @(posedge pclk);
    eof_window <= 1'b0;
    token(6'h00);
    check({31'h0, go_seen}, 32'h1);
    wrap_up();
  end

endmodule

`default_nettype wire
